// >>> core/fsl_pkg.sv
// shared constants and carriers for the host-side flash lock and bank controller
// assumes one 100 MHz clock; the flash itself is an asynchronous x16 part
package fsl_pkg;

    // ------------------------------------------------------------
    // bus widths and command data
    // ------------------------------------------------------------
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam logic [15:0] CMD_LOCK = 16'h0060;
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
    localparam logic [15:0] CMD_RESUME = 16'h0030;
    localparam logic [15:0] CMD_UNLK1 = 16'h00aa;
    localparam logic [15:0] CMD_UNLK2 = 16'h0055;
    localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [15:0] CMD_PROG = 16'h00a0;
    localparam logic [15:0] CMD_ERASE = 16'h0080;
    localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
    localparam logic [15:0] CMD_SECT_ERASE = 16'h0030;
    localparam logic [21:0] ADDR_555 = 22'h000555;
    localparam logic [21:0] ADDR_2AA = 22'h0002aa;
    localparam logic [21:0] ADDR_LOCK_STATUS = 22'h000002;
    localparam logic [15:0] LOCK_PROTECTED = 16'h0001;

    // ------------------------------------------------------------
    // address fields
    // ------------------------------------------------------------
    localparam int LOCK_SEL_BIT = 6;
    localparam int BANK_HI = 21;
    localparam int BANK_LO = 20;
    localparam int SECT_COARSE_LO = 15;
    localparam int SECT_FINE_LO = 13;
    localparam int NUM_SECTORS = 134;
    localparam int NUM_BANKS = 4;

    // ------------------------------------------------------------
    // bus-cycle timing: write pulse, hold, recovery, read access
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int T_WP_NS = 50;
    localparam int T_WC_NS = 80;
    localparam int T_ACC_NS = 70;
    localparam int T_CHOLD_NS = 3;
    localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WREC_CYC = 4'((T_WC_NS - T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + 1);
    localparam logic [3:0] HOLD_CYC = 4'((T_CHOLD_NS + CLK_NS - 1) / CLK_NS);

    // ------------------------------------------------------------
    // user operations and carriers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FSL_OP_READ, FSL_OP_LOCK, FSL_OP_UNLOCK, FSL_OP_LOCK_EXIT,
        FSL_OP_PROGRAM, FSL_OP_SECT_ERASE, FSL_OP_CHIP_ERASE,
        FSL_OP_SUSPEND, FSL_OP_RESUME, FSL_OP_RESET, FSL_OP_LOCK_QUERY
    } fsl_op_e;

    typedef struct packed {
        fsl_op_e op;
        logic [21:0] addr;
        logic [15:0] data;
    } fsl_req_s;

    typedef struct packed {
        logic chip_select_n;
        logic write_n;
        logic output_n;
        logic [21:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
    } fsl_pins_s;

    typedef struct packed {
        logic we;
        logic [21:0] addr;
        logic [15:0] data;
    } fsl_cyc_s;

endpackage

// >>> core/fsl_bus_cycle.sv
// one asynchronous flash bus cycle (write or read) paced by clock counts
// assumes the caller holds start for one cycle only while idle is high
`timescale 1ns/1ps

module fsl_bus_cycle (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // cycle request
    input wire logic start,
    input wire fsl_pkg::fsl_cyc_s cyc,
    output logic idle,
    output logic done,
    output logic [15:0] rd_data,
    // flash pins, synchronised read data in
    input wire logic [15:0] dq_in_sync,
    output fsl_pkg::fsl_pins_s pins
);

    typedef enum logic [2:0] {FSL_BC_IDLE, FSL_BC_PULSE, FSL_BC_HOLD,
                              FSL_BC_RECOVER} fsl_bc_state_e;

    fsl_bc_state_e state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic we_ff;
    logic [15:0] rd_ff;
    fsl_pkg::fsl_pins_s pins_ff, nxt_pins;
    logic done_ff;
    wire logic cnt_zero = (cnt_ff == 4'h0);

    // ------------------------------------------------------------
    // cycle sequencer: select, strobe width, hold, recovery
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_zero ? 4'h0 : cnt_ff - 4'h1;
        nxt_pins = pins_ff;
        case (state_ff)
            FSL_BC_IDLE: begin
                if (start) begin
                    nxt_state = FSL_BC_PULSE;
                    nxt_pins.chip_select_n = 1'b0;
                    nxt_pins.addr = cyc.addr;
                    nxt_pins.dq_out = cyc.data;
                    nxt_pins.dq_oe = cyc.we;
                    nxt_pins.write_n = ~cyc.we;
                    nxt_pins.output_n = cyc.we;
                    nxt_cnt = cyc.we ? fsl_pkg::WP_CYC : fsl_pkg::ACC_CYC;
                end
            end
            FSL_BC_PULSE: begin
                if (cnt_zero) begin
                    nxt_state = FSL_BC_HOLD;
                    nxt_pins.write_n = 1'b1;   // data latched on rising edge
                    nxt_pins.output_n = 1'b1;
                    nxt_cnt = fsl_pkg::HOLD_CYC;
                end
            end
            FSL_BC_HOLD: begin
                if (cnt_zero) begin
                    nxt_state = FSL_BC_RECOVER;
                    nxt_pins.chip_select_n = 1'b1;
                    nxt_pins.dq_oe = 1'b0;
                    nxt_cnt = fsl_pkg::WREC_CYC;
                end
            end
            FSL_BC_RECOVER: begin
                if (cnt_zero) begin
                    nxt_state = FSL_BC_IDLE;
                end
            end
            default: nxt_state = FSL_BC_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= FSL_BC_IDLE;
            cnt_ff <= 4'h0;
            pins_ff <= '{chip_select_n: 1'b1, write_n: 1'b1, output_n: 1'b1,
                         addr: '0, dq_out: '0, dq_oe: 1'b0};
            we_ff <= 1'b0;
            rd_ff <= 16'h0000;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pins_ff <= nxt_pins;
            done_ff <= (state_ff == FSL_BC_RECOVER) && cnt_zero;
            if (state_ff == FSL_BC_IDLE && start) begin
                we_ff <= cyc.we;
            end
            if (state_ff == FSL_BC_PULSE && cnt_zero && !we_ff) begin
                rd_ff <= dq_in_sync;   // sampled just before output enable rises
            end
        end
    end

    assign idle = (state_ff == FSL_BC_IDLE);
    assign done = done_ff;
    assign rd_data = rd_ff;
    assign pins = pins_ff;

endmodule // fsl_bus_cycle

// >>> core/fsl_host_ctrl.sv
// host controller issuing sector lock, bank and erase command sequences to the flash
// assumes the flash pins are asynchronous; read data is synchronised here
// Function
// RULE1: flash powers up with all sectors locked; host starts with shadow all locked
// RULE2: flash refuses program/erase of locked sectors; host refuses them too
// RULE3: lock sequence opens with two writes of 60h at don't-care address
// RULE4: third write carries target sector address with data 60h
// RULE5: address bit six low locks, high unlocks the sector
// RULE6: further lock cycles allowed until reset command F0h is written
// RULE7: array has four banks chosen by bank-address bits
// RULE8: bank field decodes to exactly one of four banks
// RULE9: one bank may be read while another programs, erases or identifies
// RULE10: erase-suspend written to bank of erasing sector pauses the erase
// RULE11: single sector, multiple sectors or whole chip may be erased; host erases one sector or the whole chip per request
// RULE12: identification read at sector gives 01h protected, 00h unprotected
// RULE13: every reset form returns flash to array read
// RULE14: one lock bit per sector, indexed by decoded sector, checked on writes
// RULE15: four 8K-word boot sectors at each end, others 32K words
`timescale 1ns/1ps

module fsl_host_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // user request
    input wire logic req_valid,
    input wire fsl_pkg::fsl_req_s req,
    output logic req_ready,
    // user answer
    output logic rsp_valid,
    output logic rsp_refused,
    output logic [15:0] rsp_data,
    output logic [3:0] bank_busy,
    output logic lock_seq_active,
    // flash pins
    output logic flash_chip_select_n,
    output logic flash_write_n,
    output logic flash_output_n,
    output logic [21:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in
);

    // ------------------------------------------------------------
    // sector and bank decode
    // ------------------------------------------------------------
    // boot sectors at both ends are 8K words, the rest 32K words
    function automatic logic [7:0] sector_of(input logic [21:0] a);
        logic [6:0] coarse;
        coarse = a[21:15];
        if (coarse == 7'h00)
            sector_of = {6'h00, a[14:13]};                     // [RULE15]
        else if (coarse == 7'h7f)
            sector_of = 8'd130 + {6'h00, a[14:13]};            // [RULE15]
        else
            sector_of = {1'b0, coarse} + 8'd3;
    endfunction

    // one-hot bank select from the two top address bits
    function automatic logic [3:0] bank_of(input logic [21:0] a);
        bank_of = 4'h1 << a[fsl_pkg::BANK_HI:fsl_pkg::BANK_LO];  // [RULE7] [RULE8]
    endfunction

    typedef enum logic [2:0] {FSL_IDLE, FSL_ISSUE, FSL_WAIT, FSL_ANSWER} fsl_state_e;

    fsl_state_e state_ff, nxt_state;
    logic ready_ff;
    logic [fsl_pkg::NUM_SECTORS-1:0] lock_ff;
    fsl_pkg::fsl_req_s req_ff;
    logic [2:0] step_ff, nxt_step;
    logic lockseq_ff, nxt_lockseq;
    logic [3:0] busy_ff, nxt_busy;
    logic [3:0] susp_ff, nxt_susp;
    logic rsp_valid_ff, rsp_ref_ff;
    logic [15:0] rsp_data_ff;
    logic [15:0] dq_meta_ff, dq_sync_ff;
    fsl_pkg::fsl_cyc_s cyc;
    fsl_pkg::fsl_pins_s pins;
    logic bc_idle, bc_done;
    logic [15:0] bc_rd;
    logic start;

    // ------------------------------------------------------------
    // request classification
    // ------------------------------------------------------------
    wire logic [7:0] req_sect = sector_of(req.addr);
    wire logic [3:0] req_bank = bank_of(req.addr);
    wire logic is_write_op = (req.op == fsl_pkg::FSL_OP_PROGRAM) ||
                             (req.op == fsl_pkg::FSL_OP_SECT_ERASE);
    wire logic sect_locked = lock_ff[req_sect];                  // [RULE14]
    wire logic any_locked = |lock_ff;
    wire logic refuse_lock = (is_write_op && sect_locked) ||
                             (req.op == fsl_pkg::FSL_OP_CHIP_ERASE && any_locked); // [RULE2]
    // an access to a busy bank that is not suspended is refused unless it suspends it or is a reset
    wire logic bank_clash = |(req_bank & busy_ff & ~susp_ff) &&
                            req.op != fsl_pkg::FSL_OP_SUSPEND &&
                            req.op != fsl_pkg::FSL_OP_RESET;     // [RULE9]
    wire logic refuse = refuse_lock || bank_clash;
    wire logic [2:0] steps = seq_len(req_ff.op, lockseq_ff);
    wire logic [7:0] cur_sect = sector_of(req_ff.addr);
    wire logic [3:0] cur_bank = bank_of(req_ff.addr);

    // number of bus cycles for each operation
    function automatic logic [2:0] seq_len(input fsl_pkg::fsl_op_e op, input logic inseq);
        case (op)
            fsl_pkg::FSL_OP_LOCK, fsl_pkg::FSL_OP_UNLOCK:
                seq_len = inseq ? 3'd1 : 3'd3;                   // [RULE6]
            fsl_pkg::FSL_OP_PROGRAM: seq_len = 3'd4;
            fsl_pkg::FSL_OP_SECT_ERASE, fsl_pkg::FSL_OP_CHIP_ERASE: seq_len = 3'd6;
            fsl_pkg::FSL_OP_LOCK_QUERY: seq_len = 3'd4;
            default: seq_len = 3'd1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bus cycle content for the current step
    // ------------------------------------------------------------
    always_comb begin
        cyc = '{we: 1'b1, addr: fsl_pkg::ADDR_555, data: fsl_pkg::CMD_UNLK1};
        case (req_ff.op)
            fsl_pkg::FSL_OP_LOCK, fsl_pkg::FSL_OP_UNLOCK: begin
                cyc.data = fsl_pkg::CMD_LOCK;                    // [RULE3]
                cyc.addr = 22'h000000;
                if (step_ff == steps - 3'd1) begin
                    cyc.addr = req_ff.addr;                      // [RULE4]
                    cyc.addr[fsl_pkg::LOCK_SEL_BIT] =
                        (req_ff.op == fsl_pkg::FSL_OP_UNLOCK);   // [RULE5]
                end
            end
            fsl_pkg::FSL_OP_LOCK_EXIT, fsl_pkg::FSL_OP_RESET:
                cyc.data = fsl_pkg::CMD_RESET;                   // [RULE6] [RULE13]
            fsl_pkg::FSL_OP_SUSPEND: begin
                cyc.addr = req_ff.addr;                          // [RULE10]
                cyc.data = fsl_pkg::CMD_SUSPEND;
            end
            fsl_pkg::FSL_OP_RESUME: begin
                cyc.addr = req_ff.addr;
                cyc.data = fsl_pkg::CMD_RESUME;
            end
            fsl_pkg::FSL_OP_READ:
                cyc = '{we: 1'b0, addr: req_ff.addr, data: 16'h0000};
            default: begin
                // unlock pair, command, then the op-specific tail
                case (step_ff)
                    3'd1: cyc = '{we: 1'b1, addr: fsl_pkg::ADDR_2AA, data: fsl_pkg::CMD_UNLK2};
                    3'd2: begin
                        cyc.addr = {req_ff.addr[21:20], fsl_pkg::ADDR_555[19:0]};
                        cyc.data = (req_ff.op == fsl_pkg::FSL_OP_PROGRAM) ? fsl_pkg::CMD_PROG :
                                   (req_ff.op == fsl_pkg::FSL_OP_LOCK_QUERY) ?
                                   fsl_pkg::CMD_AUTOSEL : fsl_pkg::CMD_ERASE;
                    end
                    3'd3: begin
                        if (req_ff.op == fsl_pkg::FSL_OP_PROGRAM)
                            cyc = '{we: 1'b1, addr: req_ff.addr, data: req_ff.data};
                        else if (req_ff.op == fsl_pkg::FSL_OP_LOCK_QUERY)
                            cyc = '{we: 1'b0, data: 16'h0000,             // [RULE12]
                                    addr: {req_ff.addr[21:13], 11'h000, fsl_pkg::ADDR_LOCK_STATUS[1:0]}};
                    end
                    3'd4: cyc = '{we: 1'b1, addr: fsl_pkg::ADDR_2AA, data: fsl_pkg::CMD_UNLK2};
                    3'd5: begin
                        cyc.addr = (req_ff.op == fsl_pkg::FSL_OP_SECT_ERASE) ?
                                   req_ff.addr : fsl_pkg::ADDR_555;
                        cyc.data = (req_ff.op == fsl_pkg::FSL_OP_SECT_ERASE) ?
                                   fsl_pkg::CMD_SECT_ERASE : fsl_pkg::CMD_CHIP_ERASE; // [RULE11]
                    end
                    default: ;
                endcase
            end
        endcase
    end

    // ------------------------------------------------------------
    // request sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_lockseq = lockseq_ff;
        nxt_busy = busy_ff;
        nxt_susp = susp_ff;
        start = 1'b0;
        case (state_ff)
            FSL_IDLE: begin
                nxt_step = 3'd0;
                if (req_valid && !refuse)
                    nxt_state = FSL_ISSUE;
                else if (req_valid)
                    nxt_state = FSL_ANSWER;
            end
            FSL_ISSUE: begin
                start = bc_idle;
                if (bc_idle)
                    nxt_state = FSL_WAIT;
            end
            FSL_WAIT: begin
                if (bc_done) begin
                    nxt_step = step_ff + 3'd1;
                    nxt_state = (step_ff == steps - 3'd1) ? FSL_ANSWER : FSL_ISSUE;
                end
            end
            FSL_ANSWER: begin
                nxt_state = FSL_IDLE;
                if (!rsp_ref_ff) begin
                    case (req_ff.op)
                        fsl_pkg::FSL_OP_LOCK, fsl_pkg::FSL_OP_UNLOCK: nxt_lockseq = 1'b1;
                        fsl_pkg::FSL_OP_LOCK_EXIT, fsl_pkg::FSL_OP_RESET: begin
                            nxt_lockseq = 1'b0;                  // [RULE6]
                            nxt_busy = 4'h0;
                            nxt_susp = 4'h0;
                        end
                        fsl_pkg::FSL_OP_SECT_ERASE: nxt_busy = busy_ff | cur_bank;
                        fsl_pkg::FSL_OP_CHIP_ERASE: nxt_busy = 4'hf;
                        fsl_pkg::FSL_OP_SUSPEND: nxt_susp = susp_ff | (cur_bank & busy_ff); // [RULE10]
                        fsl_pkg::FSL_OP_RESUME: nxt_susp = susp_ff & ~cur_bank;
                        default: ;
                    endcase
                end
            end
            default: nxt_state = FSL_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= FSL_IDLE;
            ready_ff <= 1'b1;
            step_ff <= 3'd0;
            lock_ff <= '1;                                       // [RULE1]
            lockseq_ff <= 1'b0;
            busy_ff <= 4'h0;
            susp_ff <= 4'h0;
            req_ff <= '0;
            rsp_valid_ff <= 1'b0;
            rsp_ref_ff <= 1'b0;
            rsp_data_ff <= 16'h0000;
            dq_meta_ff <= 16'h0000;
            dq_sync_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            ready_ff <= (nxt_state == FSL_IDLE);   // ready straight from a flop
            step_ff <= nxt_step;
            lockseq_ff <= nxt_lockseq;
            busy_ff <= nxt_busy;
            susp_ff <= nxt_susp;
            dq_meta_ff <= flash_dq_in;
            dq_sync_ff <= dq_meta_ff;
            rsp_valid_ff <= (state_ff == FSL_ANSWER);
            if (state_ff == FSL_IDLE && req_valid) begin
                req_ff <= req;
                rsp_ref_ff <= refuse;
            end
            if (state_ff == FSL_WAIT && bc_done && !cyc.we)
                rsp_data_ff <= bc_rd;
            if (state_ff == FSL_ANSWER && !rsp_ref_ff &&
                (req_ff.op == fsl_pkg::FSL_OP_LOCK || req_ff.op == fsl_pkg::FSL_OP_UNLOCK))
                lock_ff[cur_sect] <= (req_ff.op == fsl_pkg::FSL_OP_LOCK); // [RULE5] [RULE14]
            if (state_ff == FSL_ANSWER && !rsp_ref_ff && req_ff.op == fsl_pkg::FSL_OP_LOCK_QUERY)
                lock_ff[cur_sect] <= (rsp_data_ff == fsl_pkg::LOCK_PROTECTED); // [RULE12]
        end
    end

    // ------------------------------------------------------------
    // bus cycle engine and outputs
    // ------------------------------------------------------------
    fsl_bus_cycle u_cycle (
        .clk(clk),
        .reset_n(reset_n),
        .start(start),
        .cyc(cyc),
        .idle(bc_idle),
        .done(bc_done),
        .rd_data(bc_rd),
        .dq_in_sync(dq_sync_ff),
        .pins(pins)
    );

    assign req_ready = ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_refused = rsp_ref_ff;
    assign rsp_data = rsp_data_ff;
    assign bank_busy = busy_ff;
    assign lock_seq_active = lockseq_ff;
    assign flash_chip_select_n = pins.chip_select_n;
    assign flash_write_n = pins.write_n;
    assign flash_output_n = pins.output_n;
    assign flash_addr = pins.addr;
    assign flash_dq_out = pins.dq_out;
    assign flash_dq_oe = pins.dq_oe;

endmodule // fsl_host_ctrl

// >>> test/fsl_flash_model.sv
// flash partner: sector lock bits, lock sequence, array and status reads
// assumes the pins of fsl_host_ctrl; a write is latched when the write strobe rises
`timescale 1ns/1ps
module fsl_flash_model (
    // host pins
    input wire logic clk,
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [21:0] addr,
    input wire logic [15:0] dq,
    // data back to the host
    output logic [15:0] dq_in
);
    logic [133:0] lk = '1; // every sector locked at power-up
    logic [1:0] n60 = 2'h0;
    logic idm = 1'b0;
    logic [15:0] pat = 16'ha5a5;
    // sector index, boot sectors at both ends
    function automatic int sec(logic [21:0] a);
        if (a[21:15] == 7'h00) return int'(a[14:13]);
        if (a[21:15] == 7'h7f) return 130 + int'(a[14:13]);
        return int'(a[21:15]) + 3;
    endfunction
    // command decode on each finished write
    always @(posedge we_n) begin
        if (!cs_n) begin
            if (dq == 16'h0060 && n60 == 2'h2) lk[sec(addr)] <= !addr[6];
            else if (dq == 16'h0060) n60 <= n60 + 2'h1;
            else if (dq == 16'h00f0) begin
                n60 <= 2'h0;
                idm <= 1'b0;
            end
            else if (dq == 16'h0090) idm <= 1'b1;
        end
    end
    // released bus toggles so a stale value never passes
    always @(posedge clk) pat <= ~pat;
    // reads answer in any bank; status reads give the lock bit
    assign dq_in = (cs_n || oe_n) ? pat : idm ? 16'(lk[sec(addr)]) : addr[15:0] ^ 16'h5a5a;
endmodule // fsl_flash_model

// >>> test/fsl_host_ctrl_sva.sv
// timing and handshake checks on the host controller ports
// assumes binding into fsl_host_ctrl
`timescale 1ns/1ps
module fsl_host_ctrl_sva (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // user side
    input wire logic req_valid,
    input wire fsl_pkg::fsl_req_s req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_refused,
    input wire logic lock_seq_active,
    // flash strobes
    input wire logic flash_chip_select_n,
    input wire logic flash_write_n,
    input wire logic flash_output_n,
    input wire logic flash_dq_oe
);
    wire logic take = req_valid && req_ready;
    wire logic lk_go = take && (req.op == fsl_pkg::FSL_OP_LOCK || req.op == fsl_pkg::FSL_OP_UNLOCK);
    wire logic lk_end = take && req.op == fsl_pkg::FSL_OP_LOCK_EXIT;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // port checks
    a_reset_idle: assert property (disable iff (1'b0) !reset_n |=>
        flash_chip_select_n && !flash_dq_oe && req_ready) else $error("pins busy after reset");
    a_refuse_quiet: assert property (rsp_valid && rsp_refused |-> flash_chip_select_n &&
        $past(flash_chip_select_n) && $past(flash_chip_select_n, 2)) else $error("refused op hit flash");
    a_refuse_delay: assert property (rsp_valid && rsp_refused |-> $past(take, 2))
        else $error("refusal not two cycles after take");
    a_write_drives: assert property (!flash_write_n |-> flash_dq_oe &&
        !flash_chip_select_n && flash_output_n) else $error("write strobe without drive");
    a_read_release: assert property (!flash_output_n |-> !flash_dq_oe)
        else $error("host drives during read");
    a_write_pulse: assert property ($fell(flash_write_n) |-> !flash_write_n [*5])
        else $error("write pulse too short");
    a_cs_hold: assert property ($rose(flash_write_n) |-> !flash_chip_select_n)
        else $error("select released before write end");
    a_lock_enter: assert property (lk_go |-> ##[1:80] lock_seq_active)
        else $error("lock sequence not entered");
    a_lock_leave: assert property (lk_end |-> ##[1:40] !lock_seq_active)
        else $error("lock sequence not left");
endmodule // fsl_host_ctrl_sva
bind fsl_host_ctrl fsl_host_ctrl_sva u_sva (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused),
    .lock_seq_active(lock_seq_active), .flash_chip_select_n(flash_chip_select_n),
    .flash_write_n(flash_write_n), .flash_output_n(flash_output_n), .flash_dq_oe(flash_dq_oe));

// >>> test/tb.sv
// self-checking bench: lock table, bank erase and cross-bank reads
// assumes fsl_host_ctrl and the flash partner model
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    fsl_pkg::fsl_req_s req = '0;
    logic req_ready, rsp_valid, rsp_refused, lock_seq_active, cs_n, we_n, oe_n, dq_oe;
    logic [15:0] rsp_data, dq_out, dq_in;
    logic [3:0] bank_busy;
    logic [21:0] fa, a;
    logic [133:0] lk = '1;
    int err_total = 0, checks_done = 0, cyc = 0, j;
    always #5 clk = ~clk;
    fsl_host_ctrl u_dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused),
        .rsp_data(rsp_data), .bank_busy(bank_busy), .lock_seq_active(lock_seq_active),
        .flash_chip_select_n(cs_n), .flash_write_n(we_n), .flash_output_n(oe_n),
        .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
    fsl_flash_model u_mdl (.clk(clk), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .addr(fa),
        .dq(dq_out), .dq_in(dq_in));
    // sector start address from index
    function automatic logic [21:0] sa(int i);
        if (i < 4) return 22'(i) << 13;
        if (i > 129) return 22'h3f8000 + (22'(i - 130) << 13);
        return 22'(i - 3) << 15;
    endfunction
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(logic [15:0] g, logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one request, then wait for its answer
    task automatic op(fsl_pkg::fsl_op_e o, logic [21:0] ad);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req <= '{o, ad, 16'h1234};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 400);
        if (rsp_valid !== 1'b1) err_total++;
    endtask
    // status read of one sector, then back to array read
    task automatic qry(int i);
        op(fsl_pkg::FSL_OP_LOCK_QUERY, sa(i) | 22'($urandom & 32'h1f80));
        chk(rsp_data, 16'(lk[i]));
        op(fsl_pkg::FSL_OP_RESET, 22'h0);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            print_verdict;
        end
    end
    // main sequence
    initial begin
        void'($urandom(49478));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        j = 130 + int'($urandom % 4);
        op(fsl_pkg::FSL_OP_PROGRAM, sa($urandom % 134) | 22'($urandom & 32'h1fff));
        chk(16'(rsp_refused), 16'h1);
        qry($urandom % 134);
        for (int i = 0; i < 134; i++) begin
            op(fsl_pkg::FSL_OP_UNLOCK, sa(i));
            lk[i] = 1'b0;
            chk(16'(rsp_refused | !lock_seq_active), 16'h0);
        end
        op(fsl_pkg::FSL_OP_LOCK, sa(j));
        lk[j] = 1'b1;
        op(fsl_pkg::FSL_OP_LOCK_EXIT, 22'h0);
        chk(16'(lock_seq_active), 16'h0);
        qry(j);
        qry(j - 1);
        qry(3);
        op(fsl_pkg::FSL_OP_CHIP_ERASE, 22'h0);
        chk(16'(rsp_refused), 16'h1);
        op(fsl_pkg::FSL_OP_PROGRAM, sa(j));
        chk(16'(rsp_refused), 16'h1);
        for (int b = 0; b < 4; b++) begin
            a = {2'(b), 20'h40000} | 22'($urandom & 32'h7fff);
            op(fsl_pkg::FSL_OP_SECT_ERASE, a);
            chk({rsp_data[15:5], 1'b0, bank_busy}, {rsp_data[15:5], rsp_refused, 4'h1 << b});
            op(fsl_pkg::FSL_OP_READ, a ^ 22'h100000);
            chk(rsp_data, a[15:0] ^ 16'h5a5a);
            op(fsl_pkg::FSL_OP_READ, a);
            chk(16'(rsp_refused), 16'h1);
            op(fsl_pkg::FSL_OP_SUSPEND, a);
            op(fsl_pkg::FSL_OP_READ, a ^ 22'h8000);
            chk(rsp_data, a[15:0] ^ 16'hda5a);
            op(fsl_pkg::FSL_OP_RESUME, a);
            op(fsl_pkg::FSL_OP_RESET, 22'h0);
            chk(16'(bank_busy), 16'h0);
        end
        op(fsl_pkg::FSL_OP_UNLOCK, sa(j));
        op(fsl_pkg::FSL_OP_LOCK_EXIT, 22'h0);
        op(fsl_pkg::FSL_OP_CHIP_ERASE, 22'h0);
        chk(16'(rsp_refused), 16'h0);
        print_verdict;
    end
endmodule // tb
